// *** logic/usbes_event_status.sv ***
// USB event flags, transaction status, misc status and enables.
//
// What this block does
// - Flag bit 7 shows NAK busy handshake.
// - Flag bit 6 shows toggle match.
// - Flag bit 5 engine free, resets 1.
// - Flag bit 4 set on FIFO overflow.
// - A write to the flag register with byte lane 0 selected clears the four event flags, except one whose event arrives in the same cycle.
// - Flag bit 2 set on suspend or wakeup.
// - Flag bit 1 set on transfer completion.
// - Flag bit 0 set on bus reset.
// - State bits 7:6 mirror NAK and toggle.
// - State bits 5:4 give token type.
// - State bits 3:0 give endpoint number.
// - Misc bit 5 mirrors engine free.
// - Misc bit 4 shows receive FIFO not empty.
// - Misc bit 3 shows bus reset active.
// - Misc bit 2 shows suspend request.
// - Length register gives received byte count.
// - Enable bit 7 gates SOF interrupt.
// - Enable bit 6 gates NAK interrupt.
// - Enable bits 4,2,1,0 gate events; others zero.
// - Engine events set flags and request interrupt.
// - Auto pause answers NAK while transfer flagged.
// - Clear-all empties flags and FIFO while set.
`timescale 1ns/1ps
module usbes_event_status
    import usbes_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    // Wishbone slave.
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // Protocol engine, same clock.
    input  wire logic        engine_busy_in,
    input  wire logic        txn_end_in,
    input  wire logic        txn_nak_in,
    input  wire logic        txn_toggle_ok_in,
    input  wire logic [1:0]  txn_token_in,
    input  wire logic [3:0]  txn_endpoint_in,
    input  wire logic [7:0]  txn_rx_count_in,
    input  wire logic        fifo_overflow_in,
    input  wire logic        suspend_wake_in,
    input  wire logic        bus_reset_event_in,
    input  wire logic        bus_reset_level_in,
    input  wire logic        suspend_level_in,
    input  wire logic        rx_fifo_nonempty_in,
    // Results.
    output logic             irq_out,
    output logic             busy_nak_out,
    output logic             fifo_clear_out
);

    // ********************************************************
    // Address decode
    // ********************************************************
    function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
        reg_hit = (adr == off);
    endfunction

    logic read_load;
    logic write_commit;
    logic flag_write;

    usbes_wb_slave u_wb_slave (
        .clock_in         (clock_in),
        .srst_in          (srst_in),
        .wb_cyc_in        (wb_cyc_in),
        .wb_stb_in        (wb_stb_in),
        .wb_we_in         (wb_we_in),
        .wb_sel0_in       (wb_sel_in[0]),
        .wb_ack_out       (wb_ack_out),
        .read_load_out    (read_load),
        .write_commit_out (write_commit)
    );

    assign flag_write = write_commit && reg_hit(wb_adr_in, USBES_OFF_EVENT_FLAGS);

    // ********************************************************
    // Control and enable registers
    // ********************************************************
    logic [7:0] event_enables;
    logic [7:0] control;
    logic       auto_pause_enable;
    logic       clear_all_control;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            event_enables <= USBES_RST_ENABLES;
        end else if (write_commit && reg_hit(wb_adr_in, USBES_OFF_ENABLES)) begin
            event_enables <= wb_dat_in[7:0] & USBES_ENABLE_MASK;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            control <= USBES_RST_CONTROL;
        end else if (write_commit && reg_hit(wb_adr_in, USBES_OFF_CONTROL)) begin
            control <= wb_dat_in[7:0] & USBES_CONTROL_MASK;
        end
    end

    assign auto_pause_enable = control[USBES_CT_PAUSE];
    assign clear_all_control = control[USBES_CT_CLRALL];

    // ********************************************************
    // Sticky event flags
    // ********************************************************
    logic [USBES_NUM_FLAGS-1:0] event_set;
    logic [USBES_NUM_FLAGS-1:0] event_flags;
    logic                       fifo_overflow_flag;
    logic                       suspend_wake_flag;
    logic                       transfer_done_flag;
    logic                       bus_reset_flag;

    assign event_set[USBES_SF_BUSRST]   = bus_reset_event_in;
    assign event_set[USBES_SF_TRANSFER] = txn_end_in;
    assign event_set[USBES_SF_SUSPEND]  = suspend_wake_in;
    assign event_set[USBES_SF_OVERFLOW] = fifo_overflow_in;

    // Clear-all is a level, so it keeps the flags empty until software drops it.
    usbes_sticky_flags u_flags (
        .clock_in       (clock_in),
        .srst_in        (srst_in),
        .set_in         (event_set),
        .clear_in       (flag_write),
        .force_clear_in (clear_all_control),
        .flags_out      (event_flags)
    );

    assign fifo_overflow_flag = event_flags[USBES_SF_OVERFLOW];
    assign suspend_wake_flag  = event_flags[USBES_SF_SUSPEND];
    assign transfer_done_flag = event_flags[USBES_SF_TRANSFER];
    assign bus_reset_flag     = event_flags[USBES_SF_BUSRST];
    assign fifo_clear_out     = clear_all_control;

    // ********************************************************
    // Transaction results
    // ********************************************************
    logic       nak_received;
    logic       toggle_match;
    logic [1:0] token_type;
    logic [3:0] current_endpoint;
    logic [7:0] received_byte_count;

    // All results move on the same edge so software never sees a mix.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            nak_received        <= 1'b0;
            toggle_match        <= 1'b0;
            token_type          <= USBES_TOKEN_OUT;
            current_endpoint    <= 4'h0;
            received_byte_count <= 8'h00;
        end else if (txn_end_in) begin
            nak_received        <= txn_nak_in;
            toggle_match        <= txn_toggle_ok_in;
            token_type          <= txn_token_in;
            current_endpoint    <= txn_endpoint_in;
            received_byte_count <= txn_rx_count_in;
        end
    end

    // ********************************************************
    // Engine and bus status
    // ********************************************************
    logic engine_free;
    logic rx_fifo_ready;
    logic bus_reset_active;
    logic suspend_request;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            engine_free <= USBES_RST_FREE;
        end else begin
            engine_free <= !engine_busy_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            rx_fifo_ready    <= 1'b0;
            bus_reset_active <= USBES_RST_BUSRST;
            suspend_request  <= 1'b0;
        end else begin
            rx_fifo_ready    <= rx_fifo_nonempty_in && !clear_all_control;
            bus_reset_active <= bus_reset_level_in;
            suspend_request  <= suspend_level_in;
        end
    end

    // ********************************************************
    // Register images
    // ********************************************************
    logic [7:0] flag_word;
    logic [7:0] state_word;
    logic [7:0] misc_word;
    logic [7:0] read_word;

    always_comb begin
        flag_word                    = 8'h00;
        flag_word[USBES_FG_NAK]      = nak_received;
        flag_word[USBES_FG_TOGGLE]   = toggle_match;
        flag_word[USBES_FG_FREE]     = engine_free;
        flag_word[USBES_FG_OVERFLOW] = fifo_overflow_flag;
        flag_word[USBES_FG_SUSPEND]  = suspend_wake_flag;
        flag_word[USBES_FG_TRANSFER] = transfer_done_flag;
        flag_word[USBES_FG_BUSRST]   = bus_reset_flag;
    end

    assign state_word = {nak_received, toggle_match, token_type, current_endpoint};

    always_comb begin
        misc_word                   = 8'h00;
        misc_word[USBES_MS_IDLE]    = engine_free;
        misc_word[USBES_MS_RXRDY]   = rx_fifo_ready;
        misc_word[USBES_MS_BUSRST]  = bus_reset_active;
        misc_word[USBES_MS_SUSPEND] = suspend_request;
    end

    // Unmapped offsets answer normally with zero data.
    always_comb begin
        case (wb_adr_in)
            USBES_OFF_EVENT_FLAGS: read_word = flag_word;
            USBES_OFF_TXN_STATE:   read_word = state_word;
            USBES_OFF_MISC_STATE:  read_word = misc_word;
            USBES_OFF_RX_LENGTH:   read_word = received_byte_count;
            USBES_OFF_ENABLES:     read_word = event_enables;
            USBES_OFF_CONTROL:     read_word = control;
            default:               read_word = 8'h00;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            wb_dat_out <= 32'h0000_0000;
        end else if (read_load) begin
            wb_dat_out <= {24'h00_0000, read_word};
        end
    end

    // ********************************************************
    // Interrupt request and auto pause
    // ********************************************************
    logic event_irq;
    logic sof_irq;
    logic nak_irq;

    assign event_irq = |({fifo_overflow_flag, suspend_wake_flag,
                          transfer_done_flag, bus_reset_flag} &
                         {event_enables[USBES_FG_OVERFLOW], event_enables[USBES_FG_SUSPEND],
                          event_enables[USBES_FG_TRANSFER], event_enables[USBES_FG_BUSRST]});
    // SOF and NAK reasons ride on the pending transfer flag of that transaction.
    assign sof_irq   = event_enables[USBES_EN_SOF] && transfer_done_flag &&
                       (token_type == USBES_TOKEN_SOF);
    assign nak_irq   = event_enables[USBES_EN_NAK] && transfer_done_flag &&
                       nak_received;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= event_irq || sof_irq || nak_irq;
        end
    end

    // The engine keeps refusing with NAK until software clears the flag.
    assign busy_nak_out = auto_pause_enable && transfer_done_flag;

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);

    sequence s_request;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence

    sequence s_answer;
        wb_ack_out ##1 !wb_ack_out;
    endsequence

    bus_answer_a: assert property (s_request |=> s_answer)
        else $error("Wishbone ack not given once after request");

    bus_reset_set_a: assert property (
        bus_reset_event_in && !clear_all_control |=> bus_reset_flag)
        else $error("Bus reset event did not set its flag");

    overflow_set_a: assert property (
        fifo_overflow_in && !clear_all_control |=> fifo_overflow_flag)
        else $error("FIFO overflow did not set its flag");

    write_clear_a: assert property (
        flag_write && !(|event_set) && !clear_all_control |=> event_flags == 4'h0)
        else $error("Write to flag register did not clear flags");

    engine_free_a: assert property (
        ##1 engine_free == !$past(engine_busy_in))
        else $error("Engine free bit does not track busy input");

    misc_mirror_a: assert property (
        read_load && reg_hit(wb_adr_in, USBES_OFF_MISC_STATE) |=>
            wb_dat_out[USBES_MS_IDLE] == $past(flag_word[USBES_FG_FREE]))
        else $error("Misc idle bit differs from free bit");

    txn_latch_a: assert property (
        txn_end_in |=> current_endpoint == $past(txn_endpoint_in) &&
                       token_type == $past(txn_token_in) &&
                       received_byte_count == $past(txn_rx_count_in))
        else $error("Transaction results not latched at end");

    txn_hold_a: assert property (
        !txn_end_in |=> $stable(state_word) && $stable(received_byte_count))
        else $error("Transaction results changed without an end");

    irq_raise_a: assert property (
        transfer_done_flag && event_enables[USBES_FG_TRANSFER] |=> irq_out)
        else $error("Enabled transfer flag did not raise interrupt");

    pause_nak_a: assert property (
        $past(txn_end_in) && !$past(clear_all_control) && auto_pause_enable |-> busy_nak_out)
        else $error("Auto pause did not answer busy NAK");

    clear_all_a: assert property (
        clear_all_control |=> event_flags == 4'h0 && !rx_fifo_ready)
        else $error("Clear-all left a flag or FIFO state set");

endmodule // usbes_event_status

// *** logic/usbes_pkg.sv ***
// Constants shared by the USB event and status block.
package usbes_pkg;

    // ********************************************************
    // Register byte offsets on the bus
    // ********************************************************
    localparam logic [7:0] USBES_OFF_EVENT_FLAGS = 8'h00;
    localparam logic [7:0] USBES_OFF_TXN_STATE   = 8'h04;
    localparam logic [7:0] USBES_OFF_MISC_STATE  = 8'h08;
    localparam logic [7:0] USBES_OFF_RX_LENGTH   = 8'h0C;
    localparam logic [7:0] USBES_OFF_ENABLES     = 8'h10;
    localparam logic [7:0] USBES_OFF_CONTROL     = 8'h14;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int USBES_FG_NAK      = 7;
    localparam int USBES_FG_TOGGLE   = 6;
    localparam int USBES_FG_FREE     = 5;
    localparam int USBES_FG_OVERFLOW = 4;
    localparam int USBES_FG_SUSPEND  = 2;
    localparam int USBES_FG_TRANSFER = 1;
    localparam int USBES_FG_BUSRST   = 0;
    localparam int USBES_EN_SOF      = 7;
    localparam int USBES_EN_NAK      = 6;
    localparam int USBES_MS_IDLE     = 5;
    localparam int USBES_MS_RXRDY    = 4;
    localparam int USBES_MS_BUSRST   = 3;
    localparam int USBES_MS_SUSPEND  = 2;
    localparam int USBES_CT_PAUSE    = 3;
    localparam int USBES_CT_CLRALL   = 1;

    // Index of each sticky event inside the four-wide flag vector.
    localparam int USBES_NUM_FLAGS   = 4;
    localparam int USBES_SF_BUSRST   = 0;
    localparam int USBES_SF_TRANSFER = 1;
    localparam int USBES_SF_SUSPEND  = 2;
    localparam int USBES_SF_OVERFLOW = 3;

    // ********************************************************
    // Reset values and encodings
    // ********************************************************
    localparam logic [7:0] USBES_RST_ENABLES  = 8'h00;
    localparam logic [7:0] USBES_RST_CONTROL  = 8'h02;
    localparam logic [7:0] USBES_ENABLE_MASK  = 8'hD7;
    localparam logic [7:0] USBES_CONTROL_MASK = 8'h0A;
    localparam logic       USBES_RST_FREE     = 1'b1;
    localparam logic       USBES_RST_BUSRST   = 1'b1;

    typedef enum logic [1:0] {
        USBES_TOKEN_OUT   = 2'h0,
        USBES_TOKEN_SOF   = 2'h1,
        USBES_TOKEN_IN    = 2'h2,
        USBES_TOKEN_SETUP = 2'h3
    } usbes_token_t;

endpackage

// *** logic/usbes_sticky_flags.sv ***
// Sticky event flags with write clear and a forced clear.
`timescale 1ns/1ps
module usbes_sticky_flags
    import usbes_pkg::*;
(
    input  wire logic                       clock_in,
    input  wire logic                       srst_in,
    input  wire logic [USBES_NUM_FLAGS-1:0] set_in,
    input  wire logic                       clear_in,
    input  wire logic                       force_clear_in,
    output logic      [USBES_NUM_FLAGS-1:0] flags_out
);

    genvar i;
    generate
        for (i = 0; i < USBES_NUM_FLAGS; i++) begin : g_flag
            // A new event beats a software clear so no event is lost.
            always_ff @(posedge clock_in) begin
                if (srst_in) begin
                    flags_out[i] <= 1'b0;
                end else if (force_clear_in) begin
                    flags_out[i] <= 1'b0;
                end else if (set_in[i]) begin
                    flags_out[i] <= 1'b1;
                end else if (clear_in) begin
                    flags_out[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule // usbes_sticky_flags

// *** logic/usbes_wb_slave.sv ***
// Classic Wishbone handshake for the register file.
`timescale 1ns/1ps
module usbes_wb_slave (
    input  wire logic clock_in,
    input  wire logic srst_in,
    input  wire logic wb_cyc_in,
    input  wire logic wb_stb_in,
    input  wire logic wb_we_in,
    input  wire logic wb_sel0_in,
    output logic      wb_ack_out,
    output logic      read_load_out,
    output logic      write_commit_out
);

    logic request;

    assign request = wb_cyc_in && wb_stb_in;

    // The answer comes one cycle after the request and lasts one cycle.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            wb_ack_out <= 1'b0;
        end else begin
            wb_ack_out <= request && !wb_ack_out;
        end
    end

    // Read data is loaded together with ack; writes land on the edge that ends the ack cycle.
    assign read_load_out    = request && !wb_ack_out;
    assign write_commit_out = request && wb_ack_out && wb_we_in && wb_sel0_in;

endmodule // usbes_wb_slave

// *** verification/tb_top.sv ***
// Self-checking bench for the USB event and status block.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_top
    import usbes_pkg::*;
;
    logic        clock_in = 1'b0;
    logic        srst_in  = 1'b1;
    logic        wb_cyc   = 1'b0;
    logic        wb_stb   = 1'b0;
    logic        wb_we    = 1'b0;
    logic [7:0]  wb_adr   = 8'h00;
    logic [31:0] wb_dat   = 32'h0000_0000;
    logic [3:0]  wb_sel   = 4'h1;
    logic [31:0] wb_dat_out;
    logic        wb_ack_out;
    logic        irq_out, busy_nak_out, fifo_clear_out;
    logic        eng_busy, eng_end, nak, tog;
    logic [1:0]  token;
    logic [3:0]  ep;
    logic [7:0]  cnt;
    logic        start = 1'b0;
    logic [7:0]  hold  = 8'h0C;
    logic [15:0] cfg   = 16'h0000;
    logic        ev_ov = 1'b0, ev_susp = 1'b0, ev_br = 1'b0;
    logic        br_lvl = 1'b1, susp_lvl = 1'b0, rxne = 1'b0;
    logic [15:0] seed  = 16'hFF4A;
    int          error_cnt = 0, checks = 0, cyc_cnt = 0;
    logic [7:0]  r_adr [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    logic [7:0]  r_exp [7] = '{8'h20, 8'h00, 8'h28, 8'h00, 8'h00, 8'h02, 8'h00};
    logic [7:0]  ev_bit [3] = '{8'h10, 8'h04, 8'h01};

    usbes_event_status uut (.clock_in(clock_in), .srst_in(srst_in), .wb_cyc_in(wb_cyc),
        .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
        .wb_dat_in(wb_dat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
        .engine_busy_in(eng_busy), .txn_end_in(eng_end), .txn_nak_in(nak),
        .txn_toggle_ok_in(tog), .txn_token_in(token), .txn_endpoint_in(ep),
        .txn_rx_count_in(cnt), .fifo_overflow_in(ev_ov), .suspend_wake_in(ev_susp),
        .bus_reset_event_in(ev_br), .bus_reset_level_in(br_lvl),
        .suspend_level_in(susp_lvl), .rx_fifo_nonempty_in(rxne), .irq_out(irq_out),
        .busy_nak_out(busy_nak_out), .fifo_clear_out(fifo_clear_out));

    usbes_engine_model engine (.clock_in(clock_in), .srst_in(srst_in), .start_in(start),
        .hold_in(hold), .cfg_in(cfg), .busy_out(eng_busy), .end_out(eng_end),
        .nak_out(nak), .tog_out(tog), .token_out(token), .ep_out(ep), .count_out(cnt));

    // ****************************************
    // Clock, timeout and helpers
    // ****************************************
    initial begin
        forever #12.5 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    function automatic logic [15:0] xs(input logic [15:0] s);
        logic [15:0] x;
        x = s ^ (s << 7);
        x = x ^ (x >> 9);
        return x ^ (x << 8);
    endfunction

    function automatic logic exp_irq(input logic [7:0] en, input logic [15:0] c);
        return en[1] | (en[6] & c[15]) | (en[7] & (c[13:12] == 2'h1));
    endfunction

    task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                        output logic [7:0] rd);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_dat <= {24'h00_0000, wd};
        do begin
            @(posedge clock_in);
            n++;
        end while (wb_ack_out !== 1'b1 && n < 50);
        `CHK("ack", 1'b1, wb_ack_out)
        rd = wb_dat_out[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        @(posedge clock_in);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
        logic [7:0] dummy;
        xfer(1'b1, adr, wd, dummy);
    endtask

    task automatic ev(input logic [2:0] v);
        {ev_ov, ev_susp, ev_br} <= v;
        @(posedge clock_in);
        {ev_ov, ev_susp, ev_br} <= 3'b000;
        repeat (2) @(posedge clock_in);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [7:0] d, en;
        repeat (5) @(posedge clock_in);
        srst_in <= 1'b0;
        @(posedge clock_in);
        for (int i = 0; i < 7; i++) begin
            xfer(1'b0, r_adr[i], 8'h00, d);
            `CHK("reset value", r_exp[i], d)
        end
        `CHK("fifo clear", 1'b1, fifo_clear_out)
        wr(USBES_OFF_ENABLES, 8'hFF);
        xfer(1'b0, USBES_OFF_ENABLES, 8'h00, d);
        `CHK("enables", 8'hD7, d)
        // A write without the low byte lane selected must leave the register alone.
        wb_sel <= 4'h0;
        wr(USBES_OFF_ENABLES, 8'h00);
        wb_sel <= 4'h1;
        xfer(1'b0, USBES_OFF_ENABLES, 8'h00, d);
        `CHK("sel ignored", 8'hD7, d)
        $display("test registers finished");
        // Transactions: token cycles through all four codes, auto pause on one pass.
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            cfg <= (i == 0) ? {2'b11, 2'(i), 12'hFFF} : {seed[15:14], 2'(i), seed[11:0]};
            en = (i % 3 == 0) ? 8'h02 : ((i % 3 == 1) ? 8'h40 : 8'h80);
            wr(USBES_OFF_ENABLES, en);
            wr(USBES_OFF_CONTROL, (i == 5) ? 8'h08 : 8'h00);
            start <= 1'b1;
            hold  <= 8'h0C + {4'h0, seed[3:0]};
            @(posedge clock_in);
            start <= 1'b0;
            @(posedge clock_in);
            xfer(1'b0, USBES_OFF_EVENT_FLAGS, 8'h00, d);
            `CHK("free busy", 1'b0, d[5])
            xfer(1'b0, USBES_OFF_MISC_STATE, 8'h00, d);
            `CHK("idle busy", 1'b0, d[5])
            for (int n = 0; n < 300 && eng_busy === 1'b1; n++) @(posedge clock_in);
            repeat (3) @(posedge clock_in);
            `CHK("irq", exp_irq(en, cfg), irq_out)
            `CHK("busy nak", (i == 5), busy_nak_out)
            xfer(1'b0, USBES_OFF_EVENT_FLAGS, 8'h00, d);
            `CHK("flags", {cfg[15:14], 6'h22}, d)
            xfer(1'b0, USBES_OFF_TXN_STATE, 8'h00, d);
            `CHK("state", cfg[15:8], d)
            xfer(1'b0, USBES_OFF_RX_LENGTH, 8'h00, d);
            `CHK("length", cfg[7:0], d)
            wr(USBES_OFF_EVENT_FLAGS, (i % 2) ? 8'hFF : 8'h00);
            xfer(1'b0, USBES_OFF_EVENT_FLAGS, 8'h00, d);
            `CHK("cleared", 8'h20, d & 8'h3F)
            `CHK("irq off", 1'b0, irq_out)
            `CHK("nak off", 1'b0, busy_nak_out)
        end
        $display("test transactions finished");
        for (int k = 0; k < 4; k++) begin
            wr(USBES_OFF_ENABLES, (k == 3) ? 8'h00 : 8'h17);
            ev(3'b100 >> (k % 3));
            `CHK("event irq", (k != 3), irq_out)
            xfer(1'b0, USBES_OFF_EVENT_FLAGS, 8'h00, d);
            `CHK("event flag", 8'h20 | ev_bit[k % 3], d & 8'h3F)
            wr(USBES_OFF_EVENT_FLAGS, 8'hFF);
        end
        $display("test events finished");
        wr(USBES_OFF_CONTROL, 8'h02);
        rxne <= 1'b1;
        ev(3'b111);
        `CHK("clear all pin", 1'b1, fifo_clear_out)
        xfer(1'b0, USBES_OFF_EVENT_FLAGS, 8'h00, d);
        `CHK("clear all", 8'h20, d & 8'h3F)
        xfer(1'b0, USBES_OFF_MISC_STATE, 8'h00, d);
        `CHK("fifo forced", 1'b0, d[4])
        wr(USBES_OFF_CONTROL, 8'h00);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            {br_lvl, susp_lvl, rxne} <= seed[2:0];
            repeat (3) @(posedge clock_in);
            xfer(1'b0, USBES_OFF_MISC_STATE, 8'h00, d);
            `CHK("misc", {3'b001, seed[0], seed[2], seed[1], 2'b00}, d)
        end
        $display("test status finished");
        stop_test();
    end
endmodule // tb_top

// *** verification/usbes_engine_model.sv ***
// Behavioural model of the USB protocol engine that feeds the event block.
`timescale 1ns/1ps
module usbes_engine_model (
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    input  wire logic        start_in,
    input  wire logic [7:0]  hold_in,
    input  wire logic [15:0] cfg_in,
    output logic             busy_out,
    output logic             end_out,
    output logic             nak_out,
    output logic             tog_out,
    output logic      [1:0]  token_out,
    output logic      [3:0]  ep_out,
    output logic      [7:0]  count_out
);
    logic [7:0]  left;
    logic [15:0] held;

    // Fields are only valid with the end pulse; outside it they show the inverse,
    // so a block that samples at the wrong moment picks up wrong values.
    assign {nak_out, tog_out, token_out, ep_out, count_out} = end_out ? held : ~held;

    always_ff @(posedge clock_in) begin
        end_out <= 1'b0;
        if (srst_in) begin
            busy_out <= 1'b0;
            left     <= 8'h00;
            held     <= 16'h0000;
        end else if (start_in && !busy_out) begin
            busy_out <= 1'b1;
            left     <= hold_in;
            held     <= cfg_in;
        end else if (busy_out && left == 8'h00) begin
            busy_out <= 1'b0;
            end_out  <= 1'b1;
        end else if (busy_out) begin
            left <= left - 8'h01;
        end
    end
endmodule // usbes_engine_model
